/* dv/debi_bus_test.sv */
module debi_bus_test
  import debi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst_n, chip_reset_n, output_float_n, core_req, core_wr, core_fetch, hold_n;
  debi_space_t core_space;
  logic [15:0] core_addr, core_wdata, core_rdata, address_lines_i, address_lines_o;
  logic [15:0] data_lines_i, data_lines_o, dma_a, dma_d, mem_d;
  logic [15:0] last_d = 16'h0000;
  logic core_done, ready, bus_takeover_grant, bus_takeover_grant_oe, address_lines_oe;
  logic data_lines_oe, program_space_select, data_space_select, io_space_select;
  logic space_select_oe, bus_cycle_strobe_i, bus_cycle_strobe_o, bus_cycle_strobe_oe;
  logic rw_dir_i, rw_dir_o, rw_dir_oe, read_select, read_select_oe, write_enable;
  logic write_enable_oe, global_or_dma_request_i, global_or_dma_request_o;
  logic global_or_dma_request_oe, fetch_indicator, fetch_indicator_oe;
  logic dma_on, dma_s, dma_rw, dma_br, mem_drv, fetch_seen;
  logic tog = 1'b0;
  logic [3:0] waits;
  logic [9:0] all_oe;
  int err_count = 0;
  int checked = 0;

  // --------------------------------------------------------------
  // Wire resolution: released data, strobe and direction lines toggle; released address lines show the inverse of address_lines_o
  // --------------------------------------------------------------
  assign address_lines_i = dma_on ? dma_a : address_lines_oe ? address_lines_o : ~address_lines_o;
  assign data_lines_i = data_lines_oe ? data_lines_o : mem_drv ? mem_d :
                        (dma_on && !dma_rw) ? dma_d : ~last_d;
  assign bus_cycle_strobe_i = dma_on ? dma_s : bus_cycle_strobe_oe ? bus_cycle_strobe_o : tog;
  assign rw_dir_i = dma_on ? dma_rw : rw_dir_oe ? rw_dir_o : tog;
  // Request line has a pull-up
  assign global_or_dma_request_i = global_or_dma_request_oe ? global_or_dma_request_o :
                                   dma_on ? dma_br : 1'b1;
  assign all_oe = {address_lines_oe, data_lines_oe, space_select_oe, bus_cycle_strobe_oe,
                   rw_dir_oe, read_select_oe, write_enable_oe, fetch_indicator_oe,
                   bus_takeover_grant_oe, global_or_dma_request_oe};

  always @(posedge clk)
  begin
    last_d <= data_lines_i;
    tog    <= ~tog;
    if (!read_select)
      fetch_seen <= fetch_indicator;
  end

  debi_bus u_debi_bus (.clk, .rst_n, .chip_reset_n, .output_float_n, .core_req, .core_wr,
    .core_fetch, .core_space, .core_addr, .core_wdata, .core_done, .core_rdata, .hold_n,
    .ready, .bus_takeover_grant, .bus_takeover_grant_oe, .address_lines_i, .address_lines_o,
    .address_lines_oe, .data_lines_i, .data_lines_o, .data_lines_oe, .program_space_select,
    .data_space_select, .io_space_select, .space_select_oe, .bus_cycle_strobe_i,
    .bus_cycle_strobe_o, .bus_cycle_strobe_oe, .rw_dir_i, .rw_dir_o, .rw_dir_oe, .read_select,
    .read_select_oe, .write_enable, .write_enable_oe, .global_or_dma_request_i,
    .global_or_dma_request_o, .global_or_dma_request_oe, .fetch_indicator, .fetch_indicator_oe);

  debi_ext_mem u_debi_ext_mem (.clk, .rst_n, .addr(address_lines_i), .data_w(data_lines_i),
    .ps_n(program_space_select), .ds_n(data_space_select), .is_n(io_space_select),
    .sel_oe(space_select_oe), .bus_cycle_strobe_n(bus_cycle_strobe_i), .rw_n(rw_dir_i),
    .rd_n(read_select), .we_n(write_enable), .br_n(global_or_dma_request_i), .waits,
    .ready, .mem_d, .mem_drv);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (s !== v)
    begin
      err_count++;
      end_sim();
    end
  endtask : wt

  task automatic acc(input logic w, input debi_space_t sp, input logic [15:0] a,
                     input logic [15:0] d, output int n);
    int t0;
    @(negedge clk);
    core_req   = 1'b1;
    core_wr    = w;
    core_space = sp;
    core_addr  = a;
    core_wdata = d;
    t0         = int'($time);
    wt(core_done, 1'b1);
    n = (int'($time) - t0) / 50;
    @(negedge clk);
    core_req = 1'b0;
  endtask : acc

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk({10'h0, program_space_select, data_space_select, io_space_select,
         bus_cycle_strobe_o, rw_dir_o, read_select}, 16'h003F);
    chk({14'h0, address_lines_oe, data_lines_oe}, 16'h0002);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_spaces();
    logic [15:0] ta [4] = '{16'hFFFF, 16'h8001, 16'hFFFE, 16'h7FFF};
    logic [2:0]  ts [4] = '{3'h3, 3'h5, 3'h6, 3'h5};
    logic [15:0] m;
    int n;
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 3) ? 16'h7FFF : 16'hFFFF;
      acc(1'b1, debi_space_t'(i), ta[i], 16'hA5C0 + 16'(i), n);
      chk(u_debi_ext_mem.mem[{i[1:0], ta[i][5:0]}], 16'hA5C0 + 16'(i));
      chk({13'h0, u_debi_ext_mem.sel_q}, {13'h0, ts[i]});
      chk({15'h0, u_debi_ext_mem.br_q}, {15'h0, i != 3});
      chk(u_debi_ext_mem.addr_q & m, ta[i] & m);
      core_fetch = (i == 0);
      acc(1'b0, debi_space_t'(i), ta[i], 16'h0000, n);
      core_fetch = 1'b0;
      chk(core_rdata, 16'hA5C0 + 16'(i));
      chk({15'h0, u_debi_ext_mem.rd_q}, 16'h0000);
      chk({15'h0, fetch_seen}, {15'h0, i != 0});
    end
    $display("t_spaces done");
  endtask : t_spaces

  task automatic t_wait();
    int n0;
    int n3;
    acc(1'b0, DEBI_SP_DATA, 16'h8001, 16'h0000, n0);
    waits = 4'h3;
    acc(1'b0, DEBI_SP_DATA, 16'h8001, 16'h0000, n3);
    chk(core_rdata, 16'hA5C1);
    chk({15'h0, n3 > n0 && (n3 - n0) % 2 == 0}, 16'h0001);
    acc(1'b0, DEBI_SP_GLOBAL, 16'h7FFF, 16'h0000, n3);
    chk(core_rdata, 16'hA5C3);
    waits = 4'h0;
    $display("t_wait done");
  endtask : t_wait

  task automatic t_float();
    @(negedge clk);
    output_float_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h0, all_oe}, 16'h0000);
    output_float_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({15'h0, address_lines_oe}, 16'h0001);
    $display("t_float done");
  endtask : t_float

  task automatic t_dma();
    @(negedge clk);
    hold_n = 1'b0;
    wt(bus_takeover_grant, 1'b0);
    chk({6'h0, all_oe & 10'h3F9}, 16'h0000);
    @(negedge clk);
    dma_on = 1'b1;
    dma_br = 1'b0;
    dma_a  = 16'h23FF;
    dma_d  = 16'hBEEF;
    dma_rw = 1'b0;
    wt(fetch_indicator, 1'b0);
    @(negedge clk);
    dma_s = 1'b0;
    repeat (3) @(negedge clk);
    dma_s  = 1'b1;
    dma_rw = 1'b1;
    @(negedge clk);
    dma_s = 1'b0;
    repeat (4) @(negedge clk);
    chk(data_lines_o, 16'hBEEF);
    chk({15'h0, data_lines_oe}, 16'h0000);
    dma_s  = 1'b1;
    dma_br = 1'b1;
    @(negedge clk);
    dma_on = 1'b0;
    hold_n = 1'b1;
    wt(bus_takeover_grant, 1'b1);
    $display("t_dma done");
  endtask : t_dma

  task automatic t_chiprst();
    int n;
    @(negedge clk);
    core_req   = 1'b1;
    core_wr    = 1'b1;
    core_space = DEBI_SP_IO;
    core_addr  = 16'h0042;
    core_wdata = 16'h1234;
    wt(data_lines_oe, 1'b1);
    @(negedge clk);
    chip_reset_n = 1'b0;
    core_req     = 1'b0;
    repeat (4) @(negedge clk);
    chk({14'h0, data_lines_oe, bus_cycle_strobe_o}, 16'h0001);
    chip_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b0, DEBI_SP_IO, 16'hFFFE, 16'h0000, n);
    chk(core_rdata, 16'hA5C2);
    $display("t_chiprst done");
  endtask : t_chiprst

  initial
  begin
    rst_n          = 1'b0;
    chip_reset_n   = 1'b1;
    output_float_n = 1'b1;
    core_req       = 1'b0;
    core_wr        = 1'b0;
    core_fetch     = 1'b0;
    core_space     = DEBI_SP_PROG;
    core_addr      = 16'h0000;
    core_wdata     = 16'h0000;
    hold_n         = 1'b1;
    {dma_on, dma_s, dma_rw, dma_br} = 4'h7;
    dma_a          = 16'h0000;
    dma_d          = 16'h0000;
    waits          = 4'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_spaces();
    t_wait();
    t_float();
    t_dma();
    t_chiprst();
    end_sim();
  end
endmodule : debi_bus_test

/* dv/debi_ext_mem.sv */
module debi_ext_mem
  import debi_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_w,
  input  wire logic              ps_n,
  input  wire logic              ds_n,
  input  wire logic              is_n,
  input  wire logic              sel_oe,
  input  wire logic              bus_cycle_strobe_n,
  input  wire logic              rw_n,
  input  wire logic              rd_n,
  input  wire logic              we_n,
  input  wire logic              br_n,
  input  wire logic [3:0]        waits,
  output logic                   ready,
  output logic      [DATA_W-1:0] mem_d,
  output logic                   mem_drv
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [DATA_W-1:0] mem [256];
  logic [2:0]        sel_q;
  logic [ADDR_W-1:0] addr_q;
  logic              br_q;
  logic              rd_q;
  logic [3:0]        cnt_q;
  logic              act;
  logic [7:0]        idx;
  logic [7:0]        idx_q;

  // --------------------------------------------------------------
  // Decode and wait states
  // --------------------------------------------------------------
  assign idx     = {(!ps_n ? 2'h0 : !is_n ? 2'h2 : br_n ? 2'h1 : 2'h3), addr[5:0]};
  assign act     = sel_oe && (!bus_cycle_strobe_n || !br_n);
  // Low until the count runs out, so a stale high cannot end a cycle early
  assign ready   = (waits == 4'h0) || (act && cnt_q >= waits);
  assign mem_d   = mem[idx];
  assign mem_drv = sel_oe && !rd_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 4'h0;
    else if (!act)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hF)
      cnt_q <= cnt_q + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sel_oe && !bus_cycle_strobe_n)
    begin
      sel_q  <= {ps_n, ds_n, is_n};
      addr_q <= addr;
      br_q   <= br_n;
      rd_q   <= rd_n;
      idx_q  <= idx;
    end
  end

  // Data taken as write enable rises; the selects rise in the same step, so use the held index
  always @(posedge we_n)
  begin
    if (sel_oe && !rw_n)
      mem[idx_q] <= data_w;
  end
endmodule : debi_ext_mem

/* pkg/debi_pkg.sv */
package debi_pkg;

  // ----------------------------------------------------------------
  // Widths and spaces
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned GLOBAL_W    = 15;
  localparam int unsigned SARAM_AW    = 14;
  localparam int unsigned SARAM_WORDS = 9216;

  // ----------------------------------------------------------------
  // Space codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEBI_SP_PROG   = 2'h0,
    DEBI_SP_DATA   = 2'h1,
    DEBI_SP_IO     = 2'h2,
    DEBI_SP_GLOBAL = 2'h3
  } debi_space_t;

  // ----------------------------------------------------------------
  // Bus states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEBI_ST_IDLE   = 3'h0,
    DEBI_ST_GRANT  = 3'h1,
    DEBI_ST_ACCESS = 3'h2,
    DEBI_ST_DONE   = 3'h3,
    DEBI_ST_HOLD   = 3'h4
  } debi_state_t;

  // ----------------------------------------------------------------
  // Reset values of pin drivers
  // ----------------------------------------------------------------
  localparam logic       RST_SELECT_N = 1'b1;
  localparam logic       RST_STROBE_N = 1'b1;
  localparam logic       RST_DIR_READ = 1'b1;
  localparam logic [15:0] RST_ADDR    = 16'h0000;
  localparam logic [15:0] RST_DATA    = 16'h0000;

endpackage : debi_pkg

/* verilog/debi_bus.sv */
// Functional notes
// - Drive address for program, data, I/O; float in hold or output-float.
// - In hold with external request low, address lines address on-chip RAM.
// - Float data unless writing; float in reset, hold request, output-float.
// - During external DMA, data lines carry words into on-chip RAM; RAM reads load data_lines_o but are not driven.
// - Space selects high; one low per access; float in hold or output-float.
// - Ready low extends access one cycle, resampled until high.
// - Direction high by default, low for writes, floated in hold or float.
// - Strobe high except external cycle; floated in hold or output-float.
// - Read select low on every external read.
// - Read select floats in hold and output-float.
// - 64K program, data, I/O space plus 32K global data space.
// - Hold acknowledge low when hold granted; bus lines floated.
// - In hold, fetch indicator acknowledges external RAM request.
// - Global/DMA request asserted while accessing global data space.
// - Data driven from write enable fall until after its rise.
module debi_bus
  import debi_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              chip_reset_n,
  input  wire logic              output_float_n,
  input  wire logic              core_req,
  input  wire logic              core_wr,
  input  wire logic              core_fetch,
  input  wire debi_space_t       core_space,
  input  wire logic [ADDR_W-1:0] core_addr,
  input  wire logic [DATA_W-1:0] core_wdata,
  output logic                   core_done,
  output logic      [DATA_W-1:0] core_rdata,
  input  wire logic              hold_n,
  input  wire logic              ready,
  output logic                   bus_takeover_grant,
  output logic                   bus_takeover_grant_oe,
  input  wire logic [ADDR_W-1:0] address_lines_i,
  output logic      [ADDR_W-1:0] address_lines_o,
  output logic                   address_lines_oe,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   data_lines_oe,
  output logic                   program_space_select,
  output logic                   data_space_select,
  output logic                   io_space_select,
  output logic                   space_select_oe,
  input  wire logic              bus_cycle_strobe_i,
  output logic                   bus_cycle_strobe_o,
  output logic                   bus_cycle_strobe_oe,
  input  wire logic              rw_dir_i,
  output logic                   rw_dir_o,
  output logic                   rw_dir_oe,
  output logic                   read_select,
  output logic                   read_select_oe,
  output logic                   write_enable,
  output logic                   write_enable_oe,
  input  wire logic              global_or_dma_request_i,
  output logic                   global_or_dma_request_o,
  output logic                   global_or_dma_request_oe,
  output logic                   fetch_indicator,
  output logic                   fetch_indicator_oe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] ext_addr_s;
  logic [DATA_W-1:0] ext_data_s;
  logic [5:0]        ctl_s;
  logic              hold_s_n;
  logic              ready_s;
  logic              breq_s_n;
  logic              bus_cycle_strobe_s_n;
  logic              rw_s;
  logic              creset_s_n;
  logic              float_s_n;

  debi_sync #(.W(ADDR_W)) u_sync_addr (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (address_lines_i),
    .sync_out (ext_addr_s)
  );

  debi_sync #(.W(DATA_W)) u_sync_data (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (data_lines_i),
    .sync_out (ext_data_s)
  );

  debi_sync #(.W(6)) u_sync_ctl (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({hold_n, ready, global_or_dma_request_i, bus_cycle_strobe_i,
                rw_dir_i, chip_reset_n}),
    .sync_out (ctl_s)
  );

  assign hold_s_n   = ctl_s[5];
  assign ready_s    = ctl_s[4];
  assign breq_s_n   = ctl_s[3];
  assign bus_cycle_strobe_s_n   = ctl_s[2];
  assign rw_s       = ctl_s[1];
  assign creset_s_n = ctl_s[0];

  debi_sync #(.W(1)) u_sync_off (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (output_float_n),
    .sync_out (float_s_n)
  );

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  debi_state_t       state_q, state_d;
  debi_space_t       space_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              wr_q;
  logic              fetch_q;
  logic              phase_q;
  logic              bus_cycle_strobe_prev_q;
  logic              dma_rd_q;
  logic [DATA_W-1:0] ram_rdata;

  // Machine cycle is two clocks; phase_q high marks the boundary
  wire boundary   = phase_q;
  wire in_hold    = (state_q == DEBI_ST_HOLD);
  wire floated    = in_hold || !float_s_n;
  wire is_global  = (core_space == DEBI_SP_GLOBAL);
  wire dma_sel    = in_hold && !breq_s_n;
  wire dma_fall   = dma_sel && !bus_cycle_strobe_s_n && bus_cycle_strobe_prev_q;
  wire dma_write  = dma_fall && !rw_s;
  wire dma_read   = dma_fall && rw_s;
  wire ram_hit    = ext_addr_s < ADDR_W'(SARAM_WORDS);
  wire [SARAM_AW-1:0] ram_addr = ext_addr_s[SARAM_AW-1:0];

  debi_saram u_saram (
    .clk   (clk),
    .wr_en (dma_write && ram_hit),
    .addr  (ram_addr),
    .wdata (ext_data_s),
    .rdata (ram_rdata)
  );

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DEBI_ST_IDLE:
        if (!hold_s_n)
          state_d = DEBI_ST_HOLD;
        else if (core_req && boundary)
          state_d = is_global ? DEBI_ST_GRANT : DEBI_ST_ACCESS;
      DEBI_ST_GRANT:
        if (boundary && ready_s)
          state_d = DEBI_ST_ACCESS;
      DEBI_ST_ACCESS:
        if (boundary && ready_s)
          state_d = DEBI_ST_DONE;
      DEBI_ST_DONE:
        if (boundary)
          state_d = DEBI_ST_IDLE;
      DEBI_ST_HOLD:
        if (hold_s_n)
          state_d = DEBI_ST_IDLE;
      default:
        state_d = DEBI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= DEBI_ST_IDLE;
      phase_q     <= 1'b0;
      space_q     <= DEBI_SP_PROG;
      addr_q      <= RST_ADDR;
      wdata_q     <= RST_DATA;
      wr_q        <= 1'b0;
      fetch_q     <= 1'b0;
      bus_cycle_strobe_prev_q <= 1'b1;
      dma_rd_q    <= 1'b0;
    end
    else
    begin
      state_q     <= creset_s_n ? state_d : DEBI_ST_IDLE;
      phase_q     <= !phase_q;
      bus_cycle_strobe_prev_q <= bus_cycle_strobe_s_n;
      dma_rd_q    <= dma_read && ram_hit;
      if (state_q == DEBI_ST_IDLE && core_req && boundary)
      begin
        space_q <= core_space;
        addr_q  <= core_addr;
        wdata_q <= core_wdata;
        wr_q    <= core_wr;
        fetch_q <= core_fetch;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      address_lines_o          <= RST_ADDR;
      address_lines_oe         <= 1'b0;
      data_lines_o             <= RST_DATA;
      data_lines_oe            <= 1'b0;
      program_space_select     <= RST_SELECT_N;
      data_space_select        <= RST_SELECT_N;
      io_space_select          <= RST_SELECT_N;
      space_select_oe          <= 1'b0;
      bus_cycle_strobe_o       <= RST_STROBE_N;
      bus_cycle_strobe_oe      <= 1'b0;
      rw_dir_o                 <= RST_DIR_READ;
      rw_dir_oe                <= 1'b0;
      read_select              <= 1'b1;
      read_select_oe           <= 1'b0;
      write_enable             <= 1'b1;
      write_enable_oe          <= 1'b0;
      global_or_dma_request_o  <= 1'b1;
      global_or_dma_request_oe <= 1'b0;
      bus_takeover_grant       <= 1'b1;
      bus_takeover_grant_oe    <= 1'b0;
      fetch_indicator          <= 1'b1;
      fetch_indicator_oe       <= 1'b0;
      core_done                <= 1'b0;
      core_rdata               <= RST_DATA;
    end
    else
    begin
      address_lines_o          <= addr_q;
      address_lines_oe         <= !floated;
      program_space_select     <= !(state_q == DEBI_ST_ACCESS && space_q == DEBI_SP_PROG);
      data_space_select        <= !(state_q == DEBI_ST_ACCESS &&
                                    (space_q == DEBI_SP_DATA || space_q == DEBI_SP_GLOBAL));
      io_space_select          <= !(state_q == DEBI_ST_ACCESS && space_q == DEBI_SP_IO);
      space_select_oe          <= !floated;
      bus_cycle_strobe_o       <= !(state_q == DEBI_ST_ACCESS);
      bus_cycle_strobe_oe      <= !floated;
      rw_dir_o                 <= !(state_q != DEBI_ST_IDLE && state_q != DEBI_ST_HOLD
                                    && wr_q);
      rw_dir_oe                <= !floated;
      read_select              <= !(state_q == DEBI_ST_ACCESS && !wr_q);
      read_select_oe           <= !floated;
      write_enable             <= !(state_q == DEBI_ST_ACCESS && wr_q);
      write_enable_oe          <= !floated;
      global_or_dma_request_o  <= !(state_q != DEBI_ST_IDLE && state_q != DEBI_ST_HOLD
                                    && space_q == DEBI_SP_GLOBAL);
      global_or_dma_request_oe <= !floated;
      bus_takeover_grant       <= !in_hold;
      bus_takeover_grant_oe    <= float_s_n;
      fetch_indicator          <= in_hold ? !dma_sel :
                                  !(state_q == DEBI_ST_ACCESS && fetch_q);
      fetch_indicator_oe       <= float_s_n;
      if (dma_rd_q)
      begin
        data_lines_o <= ram_rdata;
      end
      else if (!in_hold)
      begin
        data_lines_o <= wdata_q;
      end
      // Write data held through the done cycle, past the write enable rise
      data_lines_oe            <= float_s_n && creset_s_n && hold_s_n &&
                                  ((state_q == DEBI_ST_ACCESS && wr_q) ||
                                   (state_q == DEBI_ST_DONE && wr_q));
      core_done                <= (state_q == DEBI_ST_DONE) && boundary;
      // Word taken a machine cycle after the access ends, as the synchroniser lags two clocks
      if (state_q == DEBI_ST_DONE && boundary && !wr_q)
      begin
        core_rdata <= ext_data_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_float_addr_pins: assert property (@(posedge clk) disable iff (!rst_n)
    $past(floated) |-> !address_lines_oe)
    else $error("address driven while floated");

  chk_data_float_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(hold_s_n) |-> !data_lines_oe)
    else $error("data driven during hold request");

  chk_one_select: assert property (@(posedge clk) disable iff (!rst_n)
    $countones({program_space_select, data_space_select, io_space_select}) >= 2)
    else $error("more than one space select low");

  chk_ready_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == DEBI_ST_ACCESS && !ready_s) |=> state_q == DEBI_ST_ACCESS)
    else $error("access ended while not ready");

  chk_dir_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
    $past(state_q == DEBI_ST_IDLE) |-> rw_dir_o)
    else $error("direction not read when idle");

  chk_strobe_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_cycle_strobe_o |-> $past(state_q == DEBI_ST_ACCESS))
    else $error("strobe low outside bus cycle");

  chk_read_select: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == DEBI_ST_ACCESS && !wr_q) |=> !read_select)
    else $error("read select missing on read");

  chk_grant_hold: assert property (@(posedge clk) disable iff (!rst_n)
    in_hold |=> !bus_takeover_grant ##0 !address_lines_oe)
    else $error("hold grant or float missing");

  chk_boundary_end: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == DEBI_ST_ACCESS && state_d == DEBI_ST_DONE) |-> phase_q)
    else $error("access ended off machine boundary");

endmodule : debi_bus

/* verilog/debi_saram.sv */
module debi_saram
  import debi_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                wr_en,
  input  wire logic [SARAM_AW-1:0] addr,
  input  wire logic [DATA_W-1:0]   wdata,
  output logic      [DATA_W-1:0]   rdata
);

  logic [DATA_W-1:0] mem_q [SARAM_WORDS];

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[addr] <= wdata;
    end
    rdata <= mem_q[addr];
  end

endmodule : debi_saram

/* verilog/debi_sync.sv */
module debi_sync
  import debi_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two stage synchroniser, first stage read only by second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : debi_sync
